// ### dv/chtsc_chk.sv
// port-level assertions of the charger supervisor
module chtsc_chk #(
  parameter int unsigned PULSE_CYCLES = 16
) (
  input wire logic       mclk_i,
  input wire logic       arst_n_i,
  input wire logic       input_overvoltage_i,
  input wire logic       die_temp_regulation_level_i,
  input wire logic       die_shutdown_level_i,
  input wire logic       int_oe_o,
  input wire logic       charge_enable_o,
  input wire logic       bat_switch_on_o,
  input wire logic       converter_on_o,
  input wire logic [2:0] input_current_limit_code_o,
  input wire logic       current_reduce_o,
  input wire logic       default_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PM1 = PULSE_CYCLES - 1;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  //////////
  a_pulse_len: assert property ($rose(int_oe_o) |-> ##PM1 (int_oe_o ##1 !int_oe_o))
    else $error("event pulse length");
  a_shut_off: assert property (die_shutdown_level_i[*5] |-> !converter_on_o && !charge_enable_o)
    else $error("shutdown left power on");
  a_shut_pulse: assert property ($rose(die_shutdown_level_i) |-> ##[1:8] int_oe_o)
    else $error("no shutdown pulse");
  a_reduce_on: assert property (die_temp_regulation_level_i[*4] |-> current_reduce_o)
    else $error("no current reduction");
  // code and mode flag leave the same flop stage
  a_dflt_limit: assert property (default_mode_o[*3] |-> input_current_limit_code_o == 3'h6)
    else $error("default limit code");
  a_dflt_charge: assert property ($rose(default_mode_o) && charge_enable_o |=> charge_enable_o)
    else $error("charging stopped on expiry");
  a_ovp_stop: assert property (input_overvoltage_i[*5] |-> !charge_enable_o)
    else $error("charging during overvoltage");
  a_chg_switch: assert property (charge_enable_o |-> bat_switch_on_o)
    else $error("charging with switch off");
  c_pulse: cover property ($rose(int_oe_o));
  c_expiry: cover property ($rose(default_mode_o));
  c_host: cover property ($fell(default_mode_o));
endmodule
bind chtsc_top chtsc_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// ### dv/chtsc_host.sv
// serial bus host model for the register port
module chtsc_host (
  input  wire logic sda_i,
  output logic      scl_o = 1'b1,
  output logic      sdl_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // a=0 start, a=1 stop; data line is set while clock low, then flips while clock high
  task automatic cond(input logic a);
    sdl_o = a;
    #40 scl_o = 1'b1;
    #40 sdl_o = !a;
    #40 scl_o = a;
  endtask
  // eight bits plus acknowledge slot; a released line reads high
  task automatic xb(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sdl_o = !d[i];
      #40 scl_o = 1'b1;
      #40 q[i] = sda_i;
      #40 scl_o = 1'b0;
      #40;
    end
  endtask
  task automatic xfer(input logic rd, input logic [7:0] a, inout logic [7:0] v, output logic nak);
    logic [8:0] q0, q1, q2;
    cond(1'b0);
    xb({chtsc_pkg::I2C_ADDR, 2'b01}, q0);
    xb({a, 1'b1}, q1);
    if (rd) begin
      cond(1'b0);
      xb({chtsc_pkg::I2C_ADDR, 2'b11}, q2);
      xb(9'h1ff, q2);
      v = q2[8:1];
    end else begin
      xb({v, 1'b1}, q2);
    end
    cond(1'b1);
    nak = q0[0] | q1[0] | (q2[0] & !rd);
  endtask
endmodule

// ### dv/test_charger_timer_status_control.sv
// self-checking bench of the charger supervisor
module test_charger_timer_status_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [14:0] f = '0;
  logic scl_i, sdl, sda_o, sda_oe_o, stat_oe_o, int_oe_o, charge_enable_o, bat_switch_on_o;
  logic converter_on_o, termination_enable_o, current_reduce_o, default_mode_o;
  logic [2:0] input_current_limit_code_o;
  wire logic sda_i = !(sdl | sda_oe_o);
  int n_mismatch = 0;
  int total_checks = 0;
  always #2.5 mclk_i = !mclk_i;
  chtsc_host host (.sda_i, .scl_o(scl_i), .sdl_o(sdl));
  chtsc_top #(.PULSE_CYCLES(16), .TICK_CYCLES(8), .WDOG_TICKS(400), .SAFETY_TICKS(3000)) DUT (
    .*, .input_overvoltage_i(f[0]), .input_undervoltage_lockout_i(f[1]), .sleep_i(f[2]),
    .bat_temp_hold_i(f[3]), .bat_temp_reduce_i(f[4]), .bat_overvoltage_i(f[5]),
    .die_temp_regulation_level_i(f[6]), .die_shutdown_level_i(f[7]),
    .die_shutdown_cleared_i(f[8]), .no_battery_i(f[9]), .iset_short_i(f[10]),
    .internal_regulator_low_i(f[11]), .precharge_i(f[12]), .input_limit_active_i(f[13]),
    .charge_term_i(f[14]));
  //////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rw(input logic rd, input logic [7:0] a, w, output logic [7:0] r);
    logic nak;
    r = w;
    host.xfer(rd, a, r, nak);
    chk("ack", 0, nak);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rw(1, 8'h01, 0, v);
    chk("ctrl", 8'h2c, v);
    rw(0, 8'h01, 8'h5e, v);
    rw(1, 8'h01, 0, v);
    chk("ctrl", 8'h5e, v);
    chk("lim", 5, input_current_limit_code_o);
    chk("bsw", 0, bat_switch_on_o);
    rw(0, 8'h01, 8'h01, v);
    cyc(4);
    chk("conv", 0, converter_on_o);
    chk("term", 0, termination_enable_o);
    chk("stat", 0, stat_oe_o);
    rw(0, 8'h01, 8'h80, v);
    rw(1, 8'h01, 0, v);
    chk("ctrl", 8'h2c, v);
    rw(1, 8'h07, 0, v);
    chk("void", 0, v);
  endtask
  task automatic t_wdog();
    logic [7:0] v;
    f[1] <= 1'b1;
    cyc(8);
    f[1] <= 1'b0;
    rw(0, 8'h01, 8'h58, v);
    rw(0, 8'h00, 8'h40, v);
    cyc(1500);
    rw(0, 8'h01, 8'h58, v);
    cyc(1500);
    chk("dflt", 0, default_mode_o);
    cyc(2500);
    chk("dflt", 1, default_mode_o);
    chk("chg", 1, charge_enable_o);
    rw(1, 8'h00, 0, v);
    chk("flag", 1, v[7]);
    rw(1, 8'h01, 0, v);
    chk("ctrl", 8'h2c, v);
    rw(0, 8'h00, 8'h00, v);
    rw(0, 8'h01, 8'h58, v);
    cyc(3500);
    chk("dflt", 0, default_mode_o);
    rw(0, 8'h01, 8'h80, v);
  endtask
  task automatic t_faults();
    logic [7:0] v;
    f[7] <= 1'b1;
    cyc(20);
    rw(1, 8'h00, 0, v);
    chk("therm", 8'h36, v[5:0]);
    f[7] <= 1'b0;
    f[8] <= 1'b1;
    cyc(20);
    f[8] <= 1'b0;
    f[6] <= 1'b1;
    cyc(20);
    chk("chg", 1, charge_enable_o);
    f[6] <= 1'b0;
    f[0] <= 1'b1;
    f[2] <= 1'b1;
    cyc(20);
    f[0] <= 1'b0;
    f[2] <= 1'b0;
    cyc(20);
    rw(1, 8'h00, 0, v);
    chk("code", 1, v[3:0]);
    rw(1, 8'h00, 0, v);
    chk("code", 3, v[3:0]);
    rw(1, 8'h00, 0, v);
    chk("stat", 8'h10, v);
    f[14] <= 1'b1;
    cyc(20);
    rw(1, 8'h00, 0, v);
    chk("done", 8'h20, v);
    f[14] <= 1'b0;
  endtask
  task automatic t_safety();
    logic [7:0] v;
    f[1] <= 1'b1;
    cyc(8);
    f[1] <= 1'b0;
    f[12] <= 1'b1;
    cyc(11000);
    chk("chg", 1, charge_enable_o);
    cyc(2000);
    chk("chg", 0, charge_enable_o);
    rw(0, 8'h01, 8'h2c, v);
    chk("chg", 0, charge_enable_o);
  endtask
  initial begin
    cyc(6);
    arst_n_i = 1'b1;
    cyc(4);
    t_regs();
    t_wdog();
    t_faults();
    t_safety();
    stop_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule

// ### hdl/chtsc_i2c.sv
// serial register port slave, sampled by the core clock
module chtsc_i2c (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  logic [1:0] scl_s_r, sda_s_r;
  logic       scl_d_r, sda_d_r;
  logic       scl, sda, rise, fall, start, stop;
  chtsc_pkg::chtsc_i2c_t st_r;
  logic [7:0] sh_r, tx_r;
  logic [3:0] cnt_r;
  logic       rw_r, first_r, inc_r;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sda_o   <= 1'b0;
    end else if (ce_i) begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl   = scl_s_r[1];
  assign sda   = sda_s_r[1];
  assign rise  = scl & ~scl_d_r;
  assign fall  = ~scl & scl_d_r;
  assign start = scl & scl_d_r & sda_d_r & ~sda;
  assign stop  = scl & scl_d_r & ~sda_d_r & sda;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r     <= chtsc_pkg::I_IDLE;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      cnt_r    <= 4'h0;
      rw_r     <= 1'b0;
      first_r  <= 1'b1;
      inc_r    <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o     <= 1'b0;
      rd_o     <= 1'b0;
      addr_o   <= 8'h00;
      wdata_o  <= 8'h00;
    end else if (ce_i) begin
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      if (start) begin
        st_r     <= chtsc_pkg::I_ADDR;
        cnt_r    <= 4'h0;
        first_r  <= 1'b1;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        st_r     <= chtsc_pkg::I_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_r)
          chtsc_pkg::I_ADDR, chtsc_pkg::I_WR: begin
            if (rise) begin
              sh_r  <= {sh_r[6:0], sda};
              cnt_r <= cnt_r + 4'h1;
            end else if (fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (st_r == chtsc_pkg::I_ADDR) begin
                if (sh_r[7:1] == chtsc_pkg::I2C_ADDR) begin
                  sda_oe_o <= 1'b1;
                  rw_r     <= sh_r[0];
                  st_r     <= chtsc_pkg::I_AACK;
                end else begin
                  st_r <= chtsc_pkg::I_IDLE;
                end
              end else begin
                sda_oe_o <= 1'b1;
                st_r     <= chtsc_pkg::I_WACK;
                inc_r    <= ~first_r;
                first_r  <= 1'b0;
                if (first_r) begin
                  addr_o <= sh_r;
                end else begin
                  wdata_o <= sh_r;
                  wr_o    <= 1'b1;
                end
              end
            end
          end
          chtsc_pkg::I_WACK: begin
            if (fall) begin
              sda_oe_o <= 1'b0;
              st_r     <= chtsc_pkg::I_WR;
              if (inc_r) begin
                addr_o <= addr_o + 8'h01;
              end
            end
          end
          chtsc_pkg::I_RD: begin
            if (fall) begin
              if (cnt_r == 4'h8) begin
                sda_oe_o <= 1'b0;
                st_r     <= chtsc_pkg::I_RACK;
              end else begin
                sda_oe_o <= ~tx_r[7];
                tx_r     <= {tx_r[6:0], 1'b0};
                cnt_r    <= cnt_r + 4'h1;
              end
            end
          end
          chtsc_pkg::I_AACK, chtsc_pkg::I_RACK: begin
            if (rise && st_r == chtsc_pkg::I_RACK) begin
              // master nack ends the read burst
              if (sda) begin
                st_r <= chtsc_pkg::I_IDLE;
              end else begin
                addr_o <= addr_o + 8'h01;
              end
            end else if (fall) begin
              if (rw_r || st_r == chtsc_pkg::I_RACK) begin
                tx_r     <= {rdata_i[6:0], 1'b0};
                sda_oe_o <= ~rdata_i[7];
                rd_o     <= 1'b1;
                cnt_r    <= 4'h1;
                st_r     <= chtsc_pkg::I_RD;
              end else begin
                sda_oe_o <= 1'b0;
                st_r     <= chtsc_pkg::I_WR;
              end
            end
          end
          default: st_r <= chtsc_pkg::I_IDLE;
        endcase
      end
    end
  end
endmodule

// ### hdl/chtsc_pkg.sv
// constants, codes and types of the charger timer and status control block
// What this block does
// - safety timer starts with a charge cycle and runs throughout charging.
// - safety expiry before termination suspends charging.
// - safety expiry gives one 256 us pulse on state and interrupt, updates faults.
// - safety timer runs double rate in precharge, regulation, temp reduction, input limit.
// - safety timer holds during overvoltage, temp hold, thermal shutdown, sleep.
// - host watchdog expires after 50 s; every host write restarts it.
// - enable bit 0 stops the watchdog, 1 enables and clears it.
// - watchdog expiry reloads default parameters and charging goes on.
// - host may reprogram after watchdog expiry; safety expiry keeps charging off.
// - timeout flag reads 1 once an enabled watchdog has expired.
// - at regulation temperature the charge current is reduced progressively.
// - shutdown temperature stops charging, converter, safety timer; pulses and updates status.
// - new charge cycle once die cools about 10 C below shutdown.
// - charge state field: ready, charging, complete, fault.
// - four bit fault code as listed, normal through input fault with regulator low.
// - successive status reads step through pending faults, then show the lowest live fault, else normal.
// - report regulator-low fault when regulator low during or leaving lockout.
// - writing 1 to control bit 7 restores all register defaults.
// - three bit input current limit code selects the limit.
// - bit 3 enables the state output, bit 2 enables termination.
// - bit 1 set inhibits charging.
// - bit 0 set puts the converter in standby.
// - state pin floats while its enable bit is clear.
// - inhibit turns the battery switch off, converter keeps the system rail.
package chtsc_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR   = 8'h01;
  localparam int TOUT_BIT    = 7;
  localparam int HEN_BIT     = 6;
  localparam int RST_BIT     = 7;
  localparam int RESISTOR_CURRENT_LIMIT_LSB    = 4;
  localparam int ENSTAT_BIT  = 3;
  localparam int ENTERM_BIT  = 2;
  localparam int INHIBIT_BIT = 1;
  localparam int STANDBY_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'hac;
  localparam logic       HEN_RESET  = 1'b0;
  localparam logic [2:0] RESISTOR_CURRENT_LIMIT_EXT   = 3'h6;
  localparam logic [1:0] CS_READY = 2'h0;
  localparam logic [1:0] CS_CHG   = 2'h1;
  localparam logic [1:0] CS_DONE  = 2'h2;
  localparam logic [1:0] CS_FAULT = 2'h3;
  localparam int NFAULT = 10;
  localparam int FI_TIMER = 6;
  localparam int FI_THERM = 5;
  localparam logic [6:0] I2C_ADDR = 7'h6a;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PULSE_TIME_US = 256;
  localparam int PULSE_CYC = (PULSE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYC = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int WDOG_TIME_S = 50;
  localparam int WDOG_TICKS = WDOG_TIME_S * 1000000 / TICK_TIME_US;
  localparam int SAFETY_TIME_MIN = 45;
  localparam int SAFETY_TICKS = SAFETY_TIME_MIN * 60 * (1000000 / TICK_TIME_US);
  localparam int CCNT_W = 18;
  localparam int TCNT_W = 22;
  typedef enum logic [2:0] {
    CH_READY = 3'b000,
    CH_RUN   = 3'b001,
    CH_DONE  = 3'b010,
    CH_TFLT  = 3'b011,
    CH_THERM = 3'b100
  } chtsc_chg_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_WR   = 3'b011,
    I_WACK = 3'b100,
    I_RD   = 3'b101,
    I_RACK = 3'b110
  } chtsc_i2c_t;
endpackage

// ### hdl/chtsc_top.sv
// charger safety timer, host watchdog, thermal sequencing and status registers
module chtsc_top #(
  parameter int unsigned PULSE_CYCLES = chtsc_pkg::PULSE_CYC,
  parameter int unsigned TICK_CYCLES  = chtsc_pkg::TICK_CYC,
  parameter int unsigned WDOG_TICKS   = chtsc_pkg::WDOG_TICKS,
  parameter int unsigned SAFETY_TICKS = chtsc_pkg::SAFETY_TICKS
) (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       input_overvoltage_i,
  input  wire logic       input_undervoltage_lockout_i,
  input  wire logic       sleep_i,
  input  wire logic       bat_temp_hold_i,
  input  wire logic       bat_temp_reduce_i,
  input  wire logic       bat_overvoltage_i,
  input  wire logic       die_temp_regulation_level_i,
  input  wire logic       die_shutdown_level_i,
  input  wire logic       die_shutdown_cleared_i,
  input  wire logic       no_battery_i,
  input  wire logic       iset_short_i,
  input  wire logic       internal_regulator_low_i,
  input  wire logic       precharge_i,
  input  wire logic       input_limit_active_i,
  input  wire logic       charge_term_i,
  output logic            stat_oe_o,
  output logic            int_oe_o,
  output logic            charge_enable_o,
  output logic            bat_switch_on_o,
  output logic            converter_on_o,
  output logic [2:0]      input_current_limit_code_o,
  output logic            termination_enable_o,
  output logic            current_reduce_o,
  output logic            default_mode_o
);
  localparam int NS = 15;
  localparam int CW = chtsc_pkg::CCNT_W;
  localparam int TW = chtsc_pkg::TCNT_W;
  localparam logic [CW-1:0] TICK_LAST  = CW'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYCLES);
  localparam logic [TW-1:0] WDOG_LAST  = TW'(WDOG_TICKS - 1);
  localparam logic [TW-1:0] SAFE_LIM   = TW'(SAFETY_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // analog comparator levels are asynchronous to the core clock
  logic [NS-1:0] raw, s1_r, s2_r;
  assign raw = {charge_term_i, input_limit_active_i, precharge_i,
                internal_regulator_low_i, iset_short_i, no_battery_i,
                die_shutdown_cleared_i, die_shutdown_level_i,
                die_temp_regulation_level_i, bat_overvoltage_i, bat_temp_reduce_i,
                bat_temp_hold_i, sleep_i, input_undervoltage_lockout_i,
                input_overvoltage_i};

  for (genvar g = 0; g < NS; g++) begin : g_sync
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
      end else if (ce_i) begin
        s1_r[g] <= raw[g];
        s2_r[g] <= s1_r[g];
      end
    end
  end

  logic input_overvoltage, input_undervoltage_lockout, slp, thold, tred, bovp, dreg, dshut, dcool, nobat, iset, ldo_low;
  logic prech, resistor_current_limit_act, cterm;
  assign input_overvoltage      = s2_r[0];
  assign input_undervoltage_lockout     = s2_r[1];
  assign slp      = s2_r[2];
  assign thold    = s2_r[3];
  assign tred     = s2_r[4];
  assign bovp     = s2_r[5];
  assign dreg     = s2_r[6];
  assign dshut    = s2_r[7];
  assign dcool    = s2_r[8];
  assign nobat    = s2_r[9];
  assign iset     = s2_r[10];
  assign ldo_low  = s2_r[11];
  assign prech    = s2_r[12];
  assign resistor_current_limit_act = s2_r[13];
  assign cterm    = s2_r[14];

  ////////////////////////////////////////////////////////////////////////////
  // register port
  logic       wr_p, rd_p;
  logic [7:0] addr, wdata, rdata;

  chtsc_i2c u_i2c (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .rdata_i  (rdata),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe_o),
    .wr_o     (wr_p),
    .rd_o     (rd_p),
    .addr_o   (addr),
    .wdata_o  (wdata)
  );

  logic       wr_stat, wr_ctrl, rd_stat, reg_rst;
  logic [6:0] ctrl_r;
  logic       hen_r, tout_r, dflt_r;
  logic       wd_exp;

  always_comb begin
    wr_stat = 1'b0;
    wr_ctrl = 1'b0;
    if (addr == chtsc_pkg::STATUS_ADDR) begin
      wr_stat = wr_p;
    end else if (addr == chtsc_pkg::CTRL_ADDR) begin
      wr_ctrl = wr_p;
    end
  end
  assign rd_stat = rd_p && (addr == chtsc_pkg::STATUS_ADDR);
  assign reg_rst = wr_ctrl && wdata[chtsc_pkg::RST_BIT];

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= chtsc_pkg::CTRL_RESET[6:0];
    end else if (ce_i) begin
      if (reg_rst || wd_exp) begin
        ctrl_r <= chtsc_pkg::CTRL_RESET[6:0];
      end else if (wr_ctrl) begin
        ctrl_r <= wdata[6:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hen_r <= chtsc_pkg::HEN_RESET;
    end else if (ce_i) begin
      if (reg_rst) begin
        hen_r <= chtsc_pkg::HEN_RESET;
      end else if (wr_stat) begin
        hen_r <= wdata[chtsc_pkg::HEN_BIT];
      end
    end
  end

  logic       inhibit, standby, en_stat, en_term;
  assign inhibit = ctrl_r[chtsc_pkg::INHIBIT_BIT];
  assign standby = ctrl_r[chtsc_pkg::STANDBY_BIT];
  assign en_stat = ctrl_r[chtsc_pkg::ENSTAT_BIT];
  assign en_term = ctrl_r[chtsc_pkg::ENTERM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // shared time base for both timers
  logic [CW-1:0] cyc_r;
  logic          tick_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      tick_r <= (cyc_r == TICK_LAST);
      cyc_r  <= (cyc_r == TICK_LAST) ? '0 : cyc_r + 1'b1;
    end
  end

  // host watchdog
  logic [TW-1:0] wd_r;
  assign wd_exp = tick_r && hen_r && (wd_r == WDOG_LAST) && !wr_p;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_r <= '0;
    end else if (ce_i) begin
      if (wr_p || !hen_r) begin
        wd_r <= '0;
      end else if (tick_r && wd_r <= WDOG_LAST) begin
        wd_r <= wd_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tout_r <= 1'b0;
      dflt_r <= 1'b1;
    end else if (ce_i) begin
      if (wd_exp) begin
        tout_r <= 1'b1;
      end else if (reg_rst) begin
        tout_r <= 1'b0;
      end
      // standalone until the host writes, and again after expiry
      if (wd_exp) begin
        dflt_r <= 1'b1;
      end else if (wr_p) begin
        dflt_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge cycle and safety timer
  chtsc_pkg::chtsc_chg_t st_r, st_nxt;
  logic [TW-1:0] sf_r;
  logic          hold, dbl, start_ok, sf_exp, evt;

  assign hold     = input_overvoltage || thold || dshut || slp || st_r == chtsc_pkg::CH_THERM;
  assign dbl      = prech || dreg || tred || resistor_current_limit_act;
  assign start_ok = !input_undervoltage_lockout && !input_overvoltage && !slp && !nobat && !inhibit && !standby && !dshut;
  assign sf_exp   = (st_r == chtsc_pkg::CH_RUN) && (sf_r >= SAFE_LIM);

  always_comb begin
    st_nxt = st_r;
    if (dshut && st_r != chtsc_pkg::CH_THERM) begin
      st_nxt = chtsc_pkg::CH_THERM;
    end else begin
      case (st_r)
        chtsc_pkg::CH_READY: begin
          if (start_ok) st_nxt = chtsc_pkg::CH_RUN;
        end
        chtsc_pkg::CH_RUN: begin
          if (sf_exp) st_nxt = chtsc_pkg::CH_TFLT;
          else if (en_term && cterm) st_nxt = chtsc_pkg::CH_DONE;
          else if (input_undervoltage_lockout || nobat) st_nxt = chtsc_pkg::CH_READY;
        end
        chtsc_pkg::CH_DONE: begin
          if (input_undervoltage_lockout || nobat) st_nxt = chtsc_pkg::CH_READY;
        end
        chtsc_pkg::CH_TFLT: begin
          // losing input power, or a thermal shutdown and cool-down, rearms a timed-out charge
          if (input_undervoltage_lockout) st_nxt = chtsc_pkg::CH_READY;
        end
        chtsc_pkg::CH_THERM: begin
          if (dcool) st_nxt = chtsc_pkg::CH_READY;
        end
        default: st_nxt = chtsc_pkg::CH_READY;
      endcase
    end
  end

  assign evt = (st_nxt != st_r) &&
               (st_nxt == chtsc_pkg::CH_TFLT || st_nxt == chtsc_pkg::CH_THERM);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= chtsc_pkg::CH_READY;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sf_r <= '0;
    end else if (ce_i) begin
      if (input_undervoltage_lockout || (st_r == chtsc_pkg::CH_READY && st_nxt == chtsc_pkg::CH_RUN)) begin
        sf_r <= '0;
      end else if (st_r == chtsc_pkg::CH_RUN && tick_r && !hold && !sf_exp) begin
        sf_r <= sf_r + (dbl ? TW'(2) : TW'(1));
      end
    end
  end

  // state and interrupt pulse
  logic [CW-1:0] pls_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pls_r <= '0;
    end else if (ce_i) begin
      if (evt) begin
        pls_r <= PULSE_LOAD;
      end else if (pls_r != '0) begin
        pls_r <= pls_r - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault capture and sequential readout
  localparam int NFAULT = chtsc_pkg::NFAULT;
  logic              uv_seen_r;
  logic [NFAULT-1:0] live, live_d_r, pend_r, clr;
  logic [3:0]        fcode;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (input_undervoltage_lockout) uv_seen_r <= 1'b1;
      else if (!ldo_low) uv_seen_r <= 1'b0;
    end
  end

  assign live = {ldo_low && (input_undervoltage_lockout || uv_seen_r), iset, nobat,
                 st_r == chtsc_pkg::CH_TFLT, st_r == chtsc_pkg::CH_THERM,
                 bovp, thold || tred, slp, input_undervoltage_lockout, input_overvoltage};

  always_comb begin
    fcode = 4'h0;
    clr   = '0;
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (live[i]) fcode = 4'(i + 1);
    end
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (pend_r[i]) fcode = 4'(i + 1);
    end
    if (rd_stat && fcode != 4'h0) clr[fcode - 4'h1] = 1'b1;
  end

  for (genvar g = 0; g < NFAULT; g++) begin : g_flt
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        live_d_r[g] <= 1'b0;
        pend_r[g]   <= 1'b0;
      end else if (ce_i) begin
        live_d_r[g] <= live[g];
        pend_r[g]   <= (pend_r[g] && !clr[g]) || (live[g] && !live_d_r[g]);
      end
    end
  end

  logic [1:0] cstate;
  always_comb begin
    if (st_r == chtsc_pkg::CH_TFLT || st_r == chtsc_pkg::CH_THERM || live != '0)
      cstate = chtsc_pkg::CS_FAULT;
    else if (st_r == chtsc_pkg::CH_RUN)
      cstate = chtsc_pkg::CS_CHG;
    else if (st_r == chtsc_pkg::CH_DONE)
      cstate = chtsc_pkg::CS_DONE;
    else
      cstate = chtsc_pkg::CS_READY;
  end

  always_comb begin
    if (addr == chtsc_pkg::STATUS_ADDR) begin
      rdata = {tout_r, hen_r, cstate, fcode};
    end else if (addr == chtsc_pkg::CTRL_ADDR) begin
      rdata = {1'b0, ctrl_r};
    end else begin
      rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power path and pin outputs
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_oe_o                  <= 1'b0;
      int_oe_o                   <= 1'b0;
      charge_enable_o            <= 1'b0;
      bat_switch_on_o            <= 1'b0;
      converter_on_o             <= 1'b0;
      input_current_limit_code_o <= chtsc_pkg::RESISTOR_CURRENT_LIMIT_EXT;
      termination_enable_o       <= 1'b0;
      current_reduce_o           <= 1'b0;
      default_mode_o             <= 1'b1;
    end else if (ce_i) begin
      stat_oe_o <= en_stat && (pls_r != '0 || st_r == chtsc_pkg::CH_RUN);
      int_oe_o  <= pls_r != '0;
      charge_enable_o <= st_r == chtsc_pkg::CH_RUN && !hold && !inhibit && !standby &&
                         !nobat && !iset;
      bat_switch_on_o <= !inhibit;
      converter_on_o  <= !standby && !hold && !input_undervoltage_lockout && !ldo_low;
      input_current_limit_code_o <= dflt_r ? chtsc_pkg::RESISTOR_CURRENT_LIMIT_EXT :
                                    ctrl_r[chtsc_pkg::RESISTOR_CURRENT_LIMIT_LSB +: 3];
      termination_enable_o <= en_term;
      current_reduce_o     <= dreg;
      default_mode_o       <= dflt_r;
    end
  end
endmodule
